/* File: rtl/fpf_format_control.sv */
// Flat-panel format control: registers, geometry counters, pixel reduction and packing.
// Assumes pixels arrive as 24-bit RGB words written by software into the pixel port.
//
// Decided for this implementation: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module fpf_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 16
) (
    input  wire logic               core_clk,
    input  wire logic               rst_n,
    input  wire logic [WIDTH-1:0]   inData,
    input  wire logic               inValid,
    output logic                    inReady,
    output logic [WIDTH-1:0]        outData,
    output logic                    outValid,
    input  wire logic               outReady,
    output logic [$clog2(DEPTH):0]  level
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr_r;
    logic [AW-1:0]    rdPtr_r;
    logic [AW:0]      count_r;
    logic             push;
    logic             pop;

    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");
    end

    assign push = inValid & inReady;
    assign pop = outValid & outReady;
    assign inReady = (count_r != DEPTH[AW:0]);
    assign outValid = (count_r != '0);
    assign outData = mem[rdPtr_r];
    assign level = count_r;

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wrPtr_r] <= inData;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) wrPtr_r <= wrPtr_r + 1'b1;
            if (pop) rdPtr_r <= rdPtr_r + 1'b1;
            count_r <= count_r + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0);
        end
    end
endmodule : fpf_fifo

// How it works
// [R1] Width register holds panel width minus one, in eight-pixel characters.
// [R2] Height means lines minus one for both single and dual drive.
// [R3] Height is ten bits: low register plus overflow bits 1 and 6.
// [R4] Horizontal counter spans 2048 pixels, vertical counter 1024 lines.
// [R5] Panel type bits 1-0: 00 single drive, 11 dual drive.
// [R6] Software enables frame buffer or accelerator when choosing dual drive.
// [R7] TFT width bit 7: 0 gives 5-6-5, 1 gives 8-8-8.
// [R8] Gray control bits 1-0: off, 16-frame STN, 2-frame TFT or mono.
// [R9] Software always writes the first two gray option bits as one.
// [R10] In 2-frame mode option three slows pattern change to alternate frames.
// [R11] Software prefers clearing option three unless panel makes own drive.
// [R12] Polynomial register holds m and n shaping the gray pattern.
// [R13] Dither bits 3-2: off, 256-colour modes only, all modes.
// [R14] Single mono: 1 or 2 at 8 bits, 4x4, 8x2, 16x1.
// [R15] Dual mono: 8 or 16 one-bit pixels per clock.
// [R16] TFT: one 5-6-5, one 8-8-8, or two 4-4-4 pixels per clock.
// [R17] Colour STN packs 3-bit pixels, averaging 2 2/3 or 5 1/3 per clock.
// [R18] Divide field selects shift clock ratio 1, 2, 4, 8 or 16.
// [R19] Counters bound active area at (width+1)*8 pixels, height+1 lines.
module fpf_format_control #(
    parameter int FIFO_DEPTH = 16,
    parameter int H_BITS = 11,
    parameter int V_BITS = 10
) (
    input  wire logic                   core_clk,
    input  wire logic                   rst_n,
    input  wire logic [fpf_pkg::ADDR_W-1:0] awaddr,
    input  wire logic                   awvalid,
    output logic                        awready,
    input  wire logic [31:0]            wdata,
    input  wire logic [3:0]             wstrb,
    input  wire logic                   wvalid,
    output logic                        wready,
    output logic [1:0]                  bresp,
    output logic                        bvalid,
    input  wire logic                   bready,
    input  wire logic [fpf_pkg::ADDR_W-1:0] araddr,
    input  wire logic                   arvalid,
    output logic                        arready,
    output logic [31:0]                 rdata,
    output logic [1:0]                  rresp,
    output logic                        rvalid,
    input  wire logic                   rready,
    output fpf_pkg::fpf_panel_type      panelOut,
    output logic                        doubleDrive
);
    import fpf_pkg::*;

    initial begin
        if (H_BITS != 11 || V_BITS != 10) $error("counters must be 11 and 10 bits");
        if (FIFO_DEPTH < 2) $error("FIFO_DEPTH too small");
    end

    logic [7:0] panelWidthChars_r;
    logic [7:0] panelHeightLow_r;
    logic [7:0] panelHeightOverflow_r;
    logic [7:0] displayTypeSelect_r;
    logic [7:0] frameBufferControl_r;
    logic [7:0] panelFormatOne_r;
    logic [7:0] panelFormatThree_r;
    logic [7:0] grayPatternPolynomial_r;
    logic [7:0] control_r;

    logic [ADDR_W-1:0] awAddr_r;
    logic [31:0]       wData_r;
    logic [3:0]        wStrb_r;
    logic              awready_r;
    logic              wready_r;
    logic              bvalid_r;
    logic [1:0]        bresp_r;
    logic              arready_r;
    logic              rvalid_r;
    logic [31:0]       rdata_r;
    logic [1:0]        rresp_r;
    logic              wrDo;
    logic              wrHit;
    logic              pixPush;

    logic [23:0]       fifoData;
    logic              fifoValid;
    logic              fifoInReady;
    logic [$clog2(FIFO_DEPTH):0] fifoLevel;
    logic              pixTake;

    logic [H_BITS-1:0] hCount_r;
    logic [V_BITS-1:0] vCount_r;
    logic [H_BITS-1:0] hLast;
    logic [V_BITS-1:0] vLast;
    logic              frameEnd;
    logic              frameOdd_r;
    logic [7:0]        lfsr_r;

    fpf_class_type     panelClass;
    logic [1:0]        frcMode;
    logic [1:0]        dithMode;
    logic [2:0]        clkDiv;
    logic [4:0]        bpp;
    logic [4:0]        outW;
    logic              bump;
    logic [23:0]       pixBits;
    logic [7:0]        redRed;
    logic [7:0]        grnRed;
    logic [7:0]        bluRed;
    logic [4:0]        chanK;
    logic [4:0]        grnK;

    logic [23:0]       acc_r;
    logic [4:0]        cnt_r;
    logic [47:0]       combined;
    logic [5:0]        newCnt;
    logic              emit;
    fpf_panel_type     panelOut_r;
    logic              doubleDrive_r;

    // Reduce an 8-bit channel to its k top bits, rounding up by one on a bump.
    function automatic logic [7:0] reduceCh(
        input logic [7:0] ch,
        input logic [4:0] k,
        input logic       up
    );
        logic [8:0] t;
        logic [8:0] top;
        t = {1'b0, ch} >> (5'd8 - k);
        top = (9'h001 << k) - 9'h001;
        if (up && t < top) t = t + 9'h001;
        return t[7:0];
    endfunction : reduceCh

    // Write channel: address and data are taken in either order, then applied together.
    assign wrHit = !awready_r && !wready_r && !bvalid_r;
    assign wrDo = wrHit && !(awAddr_r == OFF_PIXEL && !fifoInReady);
    assign pixPush = wrHit && awAddr_r == OFF_PIXEL;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
            awAddr_r <= '0;
            wData_r <= '0;
            wStrb_r <= '0;
        end else begin
            if (awvalid && awready_r) begin
                awready_r <= 1'b0;
                awAddr_r <= awaddr;
            end
            if (wvalid && wready_r) begin
                wready_r <= 1'b0;
                wData_r <= wdata;
                wStrb_r <= wstrb;
            end
            if (wrDo) begin
                bvalid_r <= 1'b1;
                // An unaligned address inside the register range is refused too.
                bresp_r <= ((awAddr_r[1:0] == 2'b00 && awAddr_r <= OFF_CTRL)
                            || awAddr_r == OFF_PIXEL) ? RESP_OKAY : RESP_SLVERR;
            end
            if (bvalid_r && bready) begin
                bvalid_r <= 1'b0;
                awready_r <= 1'b1;
                wready_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            panelWidthChars_r <= REG_RESET;
            panelHeightLow_r <= REG_RESET;
            panelHeightOverflow_r <= REG_RESET;
            displayTypeSelect_r <= REG_RESET;
            frameBufferControl_r <= REG_RESET;
            panelFormatOne_r <= REG_RESET;
            panelFormatThree_r <= REG_RESET;
            grayPatternPolynomial_r <= REG_RESET;
            control_r <= REG_RESET;
        end else if (wrDo && wStrb_r[0]) begin
            unique case (awAddr_r)
                OFF_WIDTH: panelWidthChars_r <= wData_r[7:0];
                OFF_HLOW:  panelHeightLow_r <= wData_r[7:0];
                OFF_HOVF:  panelHeightOverflow_r <= wData_r[7:0];
                OFF_DTYPE: displayTypeSelect_r <= wData_r[7:0];
                OFF_FBCTL: frameBufferControl_r <= wData_r[7:0];
                OFF_FMT1:  panelFormatOne_r <= wData_r[7:0];
                OFF_FMT3:  panelFormatThree_r <= wData_r[7:0];
                OFF_POLY:  grayPatternPolynomial_r <= wData_r[7:0];
                OFF_CTRL:  control_r <= wData_r[7:0];
                default: ;
            endcase
        end
    end

    // Read channel answers one cycle after the address is taken.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= RESP_OKAY;
        end else if (arvalid && arready_r) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rresp_r <= RESP_OKAY;
            unique case (araddr)
                OFF_WIDTH: rdata_r <= {24'h000000, panelWidthChars_r};
                OFF_HLOW:  rdata_r <= {24'h000000, panelHeightLow_r};
                OFF_HOVF:  rdata_r <= {24'h000000, panelHeightOverflow_r};
                OFF_DTYPE: rdata_r <= {24'h000000, displayTypeSelect_r};
                OFF_FBCTL: rdata_r <= {24'h000000, frameBufferControl_r};
                OFF_FMT1:  rdata_r <= {24'h000000, panelFormatOne_r};
                OFF_FMT3:  rdata_r <= {24'h000000, panelFormatThree_r};
                OFF_POLY:  rdata_r <= {24'h000000, grayPatternPolynomial_r};
                OFF_CTRL:  rdata_r <= {24'h000000, control_r};
                OFF_STAT:  rdata_r <= {4'h0, frameOdd_r, vCount_r, hCount_r,
                                       1'b0, 5'(fifoLevel)};
                OFF_PIXEL: rdata_r <= '0;
                default: begin
                    rdata_r <= '0;
                    rresp_r <= RESP_SLVERR;
                end
            endcase
        end else if (rvalid_r && rready) begin
            rvalid_r <= 1'b0;
            arready_r <= 1'b1;
        end
    end

    // A full buffer stalls the write response, which holds the master off.
    fpf_fifo #(
        .WIDTH (24),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .inData   (wData_r[23:0]),
        .inValid  (pixPush),
        .inReady  (fifoInReady),
        .outData  (fifoData),
        .outValid (fifoValid),
        .outReady (control_r[0]),
        .level    (fifoLevel)
    );

    assign pixTake = control_r[0] && fifoValid;

    // Last pixel is width*8+7, last line is the 10-bit height value.
    assign hLast = {panelWidthChars_r, 3'b111}; // R1 R19
    assign vLast = {panelHeightOverflow_r[HOVF_V9], panelHeightOverflow_r[HOVF_V8],
                    panelHeightLow_r}; // R2 R3
    assign frameEnd = pixTake && hCount_r == hLast && vCount_r == vLast;

    always_ff @(posedge core_clk) begin
        if (!rst_n || !control_r[0]) begin
            hCount_r <= '0;
            vCount_r <= '0;
        end else if (pixTake) begin
            if (hCount_r == hLast) begin // R4 R19
                hCount_r <= '0;
                vCount_r <= (vCount_r == vLast) ? '0 : vCount_r + 1'b1; // R4 R19
            end else begin
                hCount_r <= hCount_r + 1'b1;
            end
        end
    end

    // The gray pattern advances once per frame, or every other frame when slowed.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            frameOdd_r <= 1'b0;
            lfsr_r <= LFSR_SEED;
        end else if (frameEnd) begin
            frameOdd_r <= !frameOdd_r;
            if (!(frcMode == FRC_2 && panelFormatThree_r[FMT3_FRC3] && !frameOdd_r)) begin // R10
                lfsr_r <= {lfsr_r[6:0], lfsr_r[grayPatternPolynomial_r[2:0]]
                          ^ lfsr_r[grayPatternPolynomial_r[POLY_N +: 3]]}; // R12
            end
        end
    end

    assign frcMode = panelFormatOne_r[1:0];
    assign dithMode = panelFormatOne_r[FMT1_DITH +: 2];
    assign clkDiv = panelFormatOne_r[FMT1_CD +: 3];
    assign panelClass = fpf_class_type'(control_r[CTRL_CLASS +: 2]);

    // Gray control and dither only round the reduced value up on chosen pixels.
    always_comb begin
        bump = 1'b0;
        if (frcMode == FRC_16 || frcMode == FRC_2) begin // R8
            bump = lfsr_r[0] ^ hCount_r[0] ^ vCount_r[0];
        end
        if (dithMode == DITH_ALL ||
            (dithMode == DITH_256 && control_r[CTRL_PAL8])) begin // R13
            bump = bump | (hCount_r[0] ^ vCount_r[1]);
        end
    end

    // Bits per pixel and bus width; the ratio of the two is pixels per shift clock.
    always_comb begin
        bpp = 5'd8;
        outW = 5'd8;
        unique case (panelClass)
            CLS_TFT: begin
                if (clkDiv == 3'd1) begin // R16
                    bpp = 5'd12;
                    outW = 5'd24;
                end else if (panelFormatOne_r[FMT1_TFT24]) begin // R7
                    bpp = 5'd24;
                    outW = 5'd24;
                end else begin
                    bpp = 5'd16;
                    outW = 5'd16;
                end
            end
            CLS_STN: begin
                bpp = 5'd3; // R17
                outW = (clkDiv == 3'd0) ? 5'd8 : 5'd16; // R17
            end
            default: begin
                if (doubleDrive_r) begin
                    bpp = 5'd1; // R15
                    outW = (clkDiv == 3'd3) ? 5'd8 : 5'd16; // R15
                end else begin
                    unique case (clkDiv) // R14 R18
                        3'd0: begin bpp = 5'd8; outW = 5'd8; end
                        3'd1: begin bpp = 5'd8; outW = 5'd16; end
                        3'd2: begin bpp = 5'd4; outW = 5'd16; end
                        3'd3: begin bpp = 5'd2; outW = 5'd16; end
                        default: begin bpp = 5'd1; outW = 5'd16; end
                    endcase
                end
            end
        endcase
    end

    assign chanK = (bpp == 5'd16) ? 5'd5 : (bpp == 5'd12) ? 5'd4 :
                   (bpp == 5'd3) ? 5'd1 : 5'd8;
    assign grnK = (panelClass == CLS_MONO || panelClass > CLS_STN) ? bpp :
                  (bpp == 5'd16) ? 5'd6 : chanK;
    assign redRed = reduceCh(fifoData[23:16], chanK, bump);
    assign grnRed = reduceCh(fifoData[15:8], grnK, bump);
    assign bluRed = reduceCh(fifoData[7:0], chanK, bump);

    // Blue sits on the lowest pins so the first colour lands first.
    always_comb begin
        pixBits = '0;
        unique case (bpp)
            5'd24: pixBits = {redRed, grnRed, bluRed};
            5'd16: pixBits = {8'h00, redRed[4:0], grnRed[5:0], bluRed[4:0]};
            5'd12: pixBits = {12'h000, redRed[3:0], grnRed[3:0], bluRed[3:0]};
            5'd3:  pixBits = {21'h000000, redRed[0], grnRed[0], bluRed[0]};
            default: pixBits = {16'h0000, grnRed};
        endcase
    end

    // Pixels are packed lowest pins first; a word leaves whenever the bus fills.
    assign combined = {24'h000000, acc_r} | ({24'h000000, pixBits} << cnt_r);
    assign newCnt = {1'b0, cnt_r} + {1'b0, bpp};
    assign emit = pixTake && newCnt >= {1'b0, outW};

    always_ff @(posedge core_clk) begin
        if (!rst_n || !control_r[0]) begin
            acc_r <= '0;
            cnt_r <= '0;
        end else if (emit) begin
            acc_r <= 24'(combined >> outW); // R17
            cnt_r <= 5'(newCnt - {1'b0, outW});
        end else if (pixTake) begin
            acc_r <= combined[23:0];
            cnt_r <= newCnt[4:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            panelOut_r <= '0;
        end else begin
            panelOut_r.shiftClk <= emit; // R18
            panelOut_r.lineStart <= pixTake && hCount_r == '0;
            panelOut_r.frameStart <= pixTake && hCount_r == '0 && vCount_r == '0;
            panelOut_r.active <= control_r[0];
            if (emit) begin
                panelOut_r.data <= combined[23:0] & ((24'h000001 << outW) - 24'h000001);
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            doubleDrive_r <= 1'b0;
        end else begin
            doubleDrive_r <= (displayTypeSelect_r[1:0] == PT_DD); // R5
        end
    end

    assign awready = awready_r;
    assign wready = wready_r;
    assign bvalid = bvalid_r;
    assign bresp = bresp_r;
    assign arready = arready_r;
    assign rvalid = rvalid_r;
    assign rdata = rdata_r;
    assign rresp = rresp_r;
    assign panelOut = panelOut_r;
    assign doubleDrive = doubleDrive_r;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    property p_hwrap;
        pixTake && hCount_r == hLast |=> hCount_r == '0;
    endproperty
    a_hwrap: assert property (p_hwrap) else $error("line did not wrap"); // R19

    property p_vwrap;
        frameEnd |=> vCount_r == '0 && hCount_r == '0;
    endproperty
    a_vwrap: assert property (p_vwrap) else $error("frame did not wrap"); // R3

    property p_hbound;
        hCount_r <= hLast || $changed(panelWidthChars_r);
    endproperty
    a_hbound: assert property (p_hbound) else $error("pixel past line end"); // R4

    property p_ptype;
        displayTypeSelect_r[1:0] == PT_DD ##1 displayTypeSelect_r[1:0] == PT_DD
            |-> doubleDrive_r;
    endproperty
    a_ptype: assert property (p_ptype) else $error("dual drive not decoded"); // R5

    property p_tftw;
        panelClass == CLS_TFT && clkDiv == 3'd0 |->
            outW == (panelFormatOne_r[FMT1_TFT24] ? 5'd24 : 5'd16);
    endproperty
    a_tftw: assert property (p_tftw) else $error("wrong TFT width"); // R7

    property p_slow;
        frameEnd && frcMode == FRC_2 && panelFormatThree_r[FMT3_FRC3] && !frameOdd_r
            |=> $stable(lfsr_r);
    endproperty
    a_slow: assert property (p_slow) else $error("pattern changed on odd frame"); // R10

    property p_nodith;
        frcMode == FRC_OFF && dithMode == DITH_OFF |-> !bump;
    endproperty
    a_nodith: assert property (p_nodith) else $error("rounding while disabled"); // R13

    property p_ddmono;
        panelClass == CLS_MONO && doubleDrive_r |-> bpp == 5'd1;
    endproperty
    a_ddmono: assert property (p_ddmono) else $error("dual mono not one bit"); // R15

    property p_ratio;
        panelClass == CLS_MONO && !doubleDrive_r && clkDiv <= 3'd4 |->
            outW == bpp * (5'd1 << clkDiv);
    endproperty
    a_ratio: assert property (p_ratio) else $error("wrong pixels per shift"); // R18

    property p_stn;
        panelClass == CLS_STN && clkDiv == 3'd0 && pixTake && cnt_r == 5'd6
            |-> emit ##1 panelOut_r.shiftClk;
    endproperty
    a_stn: assert property (p_stn) else $error("STN byte not emitted"); // R17
endmodule : fpf_format_control
`default_nettype wire

/* File: shared/fpf_pkg.sv */
// Shared constants and types of the flat-panel format control block.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses.
`default_nettype none
package fpf_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_WIDTH = 8'h00;
    localparam logic [7:0] OFF_HLOW  = 8'h04;
    localparam logic [7:0] OFF_HOVF  = 8'h08;
    localparam logic [7:0] OFF_DTYPE = 8'h0c;
    localparam logic [7:0] OFF_FBCTL = 8'h10;
    localparam logic [7:0] OFF_FMT1  = 8'h14;
    localparam logic [7:0] OFF_FMT3  = 8'h18;
    localparam logic [7:0] OFF_POLY  = 8'h1c;
    localparam logic [7:0] OFF_CTRL  = 8'h20;
    localparam logic [7:0] OFF_STAT  = 8'h24;
    localparam logic [7:0] OFF_PIXEL = 8'h28;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] LFSR_SEED = 8'h01;
    localparam int HOVF_V8 = 1;
    localparam int HOVF_V9 = 6;
    localparam int FMT1_DITH = 2;
    localparam int FMT1_CD = 4;
    localparam int FMT1_TFT24 = 7;
    localparam int FMT3_FRC3 = 6;
    localparam int POLY_N = 4;
    localparam int CTRL_CLASS = 1;
    localparam int CTRL_PAL8 = 3;
    localparam logic [1:0] PT_SS = 2'b00;
    localparam logic [1:0] PT_DD = 2'b11;
    localparam logic [1:0] FRC_OFF = 2'b00;
    localparam logic [1:0] FRC_16 = 2'b01;
    localparam logic [1:0] FRC_2 = 2'b10;
    localparam logic [1:0] DITH_OFF = 2'b00;
    localparam logic [1:0] DITH_256 = 2'b01;
    localparam logic [1:0] DITH_ALL = 2'b10;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    typedef enum logic [1:0] {
        CLS_MONO = 2'b00,
        CLS_TFT  = 2'b01,
        CLS_STN  = 2'b10
    } fpf_class_type;
    typedef struct packed {
        logic [23:0] data;
        logic        shiftClk;
        logic        lineStart;
        logic        frameStart;
        logic        active;
    } fpf_panel_type;
endpackage : fpf_pkg
`default_nettype wire

/* File: verification/fpf_panel_model.sv */
// Panel model: latches each word shifted out of the block.
// Assumes the panel bus of fpf_format_control on the same clock.
`timescale 1ns/1ps
`default_nettype none
module fpf_panel_model (
    input  wire logic                   core_clk,
    input  wire fpf_pkg::fpf_panel_type panelIn,
    output logic [23:0]                 word,
    output logic                        seen
);
    import fpf_pkg::*;
    // Data is only trusted with the shift pulse, so both are latched together.
    always_ff @(posedge core_clk) begin
        seen <= panelIn.shiftClk;
        word <= panelIn.data;
    end
endmodule : fpf_panel_model
`default_nettype wire

/* File: verification/tb_top.sv */
// Bench for flat-panel format control: register bus, pixel FIFO and panel words.
// Assumes the panel model latches every shifted word.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import fpf_pkg::*;
    logic          core_clk = 1'h0;
    logic          rst_n = 1'h0;
    logic [7:0]    awaddr = 8'h0, araddr = 8'h0;
    logic [31:0]   wdata = 32'h0, rdata;
    logic [3:0]    wstrb = 4'hf;
    logic          awvalid = 1'h0, wvalid = 1'h0, arvalid = 1'h0;
    logic          bready = 1'h1, rready = 1'h1;
    logic          awready, wready, bvalid, arready, rvalid, doubleDrive, seen;
    logic [1:0]    bresp, rresp;
    logic [23:0]   word, p, pxMask = 24'h0;
    logic [47:0]   st;
    fpf_panel_type panelOut;
    logic [33:0]   expRd[$];
    logic [23:0]   expPx[$];
    int            n_errors = 0, comparisons = 0, seed = 32'hd7d3, t, i, m, nFrm = 0, nLine = 0;
    fpf_format_control i_dut (.core_clk, .rst_n, .awaddr, .awvalid, .awready, .wdata,
        .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
        .rdata, .rresp, .rvalid, .rready, .panelOut, .doubleDrive);
    fpf_panel_model i_pm (.core_clk, .panelIn(panelOut), .word, .seen);
    initial forever #25 core_clk = ~core_clk;
    task automatic chk(input string s, input logic [33:0] e, input logic [33:0] g);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict
    task automatic lim();
        if (t >= 99) begin
            n_errors++;
            give_verdict();
        end
    endtask : lim
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        t = 0;
        do begin
            @(posedge core_clk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
            t++;
        end while (!bvalid && t < 99);
        chk("bresp", 34'(e), 34'(bresp));
        lim();
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        araddr <= a;
        arvalid <= 1'h1;
        expRd.push_back(e);
        t = 0;
        do begin
            @(posedge core_clk);
            if (arready) arvalid <= 1'h0;
            t++;
        end while (!rvalid && t < 99);
        lim();
    endtask : rd
    always @(posedge core_clk) begin
        if (rvalid && expRd.size() > 0) chk("rdata", expRd.pop_front(), {rresp, rdata});
        if (seen && expPx.size() > 0) chk("pixel", 34'(expPx.pop_front()), 34'(word & pxMask));
        nFrm += panelOut.frameStart;
        nLine += panelOut.lineStart;
    end
    initial begin
        repeat (20) @(posedge core_clk);
        rst_n <= 1'h1;
        @(posedge core_clk);
        for (i = 0; i < 7; i++) rd(8'(4 * i), 34'h0);
        $display("test reset values done");
        for (i = 0; i < 5; i++) begin
            m = $random(seed);
            wr(8'(4 * i), m, RESP_OKAY);
            rd(8'(4 * i), {RESP_OKAY, 24'h0, m[7:0]});
        end
        wr(8'h30, m, RESP_SLVERR);
        rd(8'h30, {RESP_SLVERR, 32'h0});
        $display("test registers done");
        wr(OFF_FBCTL, 32'h1, RESP_OKAY);
        // Dual drive goes first so that the pixel tests below run single drive.
        for (i = 0; i < 2; i++) begin
            wr(OFF_DTYPE, i ? 32'h0 : 32'h3, RESP_OKAY);
            repeat (2) @(posedge core_clk);
            chk("doubleDrive", 34'(i == 0), 34'(doubleDrive));
        end
        $display("test panel type done");
        // Option three stays clear for the better picture.
        wr(OFF_FMT3, 32'hc, RESP_OKAY);
        // Sixteen pixels make exactly one line of a two-character panel.
        wr(OFF_WIDTH, 32'h1, RESP_OKAY);
        wr(OFF_HLOW, 32'h3, RESP_OKAY);
        for (m = 0; m < 4; m++) begin
            wr(OFF_CTRL, 32'(m == 3 ? 4 : m ? 2 : 0), RESP_OKAY);
            wr(OFF_FMT1, m == 1 ? 32'h80 : 32'h0, RESP_OKAY);
            pxMask <= m == 1 ? 24'hffffff : m == 2 ? 24'hffff : 24'hff;
            for (i = 0; i < 16; i++) begin
                p = $random(seed);
                wr(OFF_PIXEL, {8'h0, p}, RESP_OKAY);
                st[3 * i +: 3] = {p[23], p[15], p[7]};
                if (m < 3) expPx.push_back(m == 1 ? p : m ? {8'h0, p[23:19], p[15:10], p[7:3]}
                    : {16'h0, p[15:8]});
            end
            for (i = 0; m == 3 && i < 6; i++) expPx.push_back(24'(st[8 * i +: 8]));
            rd(OFF_STAT, 34'h10);
            wr(OFF_CTRL, 32'(m == 3 ? 5 : m ? 3 : 1), RESP_OKAY);
            for (t = 0; t < 99 && expPx.size() > 0; t++) @(posedge core_clk);
            lim();
            rd(OFF_STAT, 34'h20000);
            chk("active", 34'h1, 34'(panelOut.active));
            $display("test pixel mode %0d done", m);
        end
        chk("frameStart", 34'h4, 34'(nFrm));
        chk("lineStart", 34'h4, 34'(nLine));
        give_verdict();
    end
endmodule : tb_top
`default_nettype wire
